// >>> include/tdm_param_pkg.sv
// Constants shared by the decoder and the channel packer
package tdm_param_pkg;

    // --
    // Transfer widths
    // --
    localparam int GEN_IDX_W = 12;
    localparam int PM_IDX_W = 6;
    localparam int GEN_DATA_W = 20;
    localparam int PM_DATA_W = 26;
    localparam int GAIN_W = 18;
    localparam int ANGLE_W = 18;
    localparam int NUM_GAINS = 4;
    localparam int NUM_INV = 2;
    localparam int NUM_PHASE = 3;

    // --
    // General test parameter indices
    // --
    localparam logic [11:0] IDX_GAIN_MOTOR = 12'h06e;
    localparam logic [11:0] IDX_GAIN_LINK = 12'h06f;
    localparam logic [11:0] IDX_GAIN_RESOLVER = 12'h070;
    localparam logic [11:0] IDX_GAIN_BATTERY = 12'h071;
    localparam logic [11:0] IDX_SPEED_FACTOR = 12'h07d;
    localparam logic [11:0] IDX_ELEC_OFFSET = 12'h07e;
    localparam logic [11:0] IDX_MECH_OFFSET = 12'h07f;
    localparam logic [11:0] IDX_INV1_OPEN = 12'h082;
    localparam logic [11:0] IDX_INV1_CTRL = 12'h083;
    localparam logic [11:0] IDX_INV2_OPEN = 12'h084;
    localparam logic [11:0] IDX_INV2_CONDUCT = 12'h085;

    // --
    // Machine parameter indices
    // --
    localparam logic [5:0] IDX_RS_A = 6'h01;
    localparam logic [5:0] IDX_RS_B = 6'h02;
    localparam logic [5:0] IDX_RS_C = 6'h03;
    localparam logic [5:0] IDX_FLUX_0 = 6'h07;
    localparam logic [5:0] IDX_FLUX_1 = 6'h08;
    localparam logic [5:0] IDX_HIGH_IMP = 6'h09;

    // --
    // Fault word fields
    // --
    localparam int POS_W = 6;
    localparam int FW_LINK_SHORT = 0;
    localparam int FW_AC_SHORT = 1;
    localparam int FW_SW_OFF_LSB = 2;
    localparam int FW_DIODE_OFF_LSB = 8;
    localparam int FW_BOTH_OFF_LSB = 14;
    localparam int FX_CONDUCT_LSB = 0;
    localparam int FX_OPEN_PHASE_LSB = 6;
    localparam int FX_DISABLE_ALL = 9;
    localparam int FX_ENABLE_ALL = 10;
    localparam int FX_TRIG_LSB = 11;
    localparam int INV1_CTRL_W = 13;

    // --
    // Reset values
    // --
    localparam logic [17:0] GAIN_RST = 18'h08000;
    localparam logic [25:0] HIGH_IMP_RST = 26'h0600000;

    // --
    // Register port
    // --
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RB_SEL = 8'h04;
    localparam logic [7:0] REG_RB_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int RB_SPACE_BIT = 12;

    // --
    // Output channels
    // --
    localparam int NUM_CHAN = 12;
    localparam int SUB_W = 16;
    localparam int CHAN_W = 32;
    localparam int SCALE_DROP = 2;

endpackage

// >>> hw/output_channel_pack.sv
// Packs two 16-bit sub-channels into one registered 32-bit channel word
`timescale 1ns/1ps

module output_channel_pack
    import tdm_param_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [SUB_W-1:0] lo_in,
    input wire logic [SUB_W-1:0] hi_in,
    output logic [CHAN_W-1:0] word_out
);

    logic [CHAN_W-1:0] word_d;
    logic [CHAN_W-1:0] word_q;

    // The two halves are independent values, never one 32-bit number
    always_comb begin
        word_d = {hi_in, lo_in};
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= '0;
        end else begin
            word_q <= word_d;
        end
    end

    assign word_out = word_q;

endmodule // output_channel_pack

// >>> hw/tdm_param_fault_decoder.sv
// Multiplexed parameter receiver, fault decoder and output channel packer
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module tdm_param_fault_decoder
    import tdm_param_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic gen_valid,
    input wire logic [GEN_IDX_W-1:0] gen_index,
    input wire logic [GEN_DATA_W-1:0] gen_data,
    input wire logic pm_valid,
    input wire logic [PM_IDX_W-1:0] pm_index,
    input wire logic [PM_DATA_W-1:0] pm_data,
    input wire logic [REG_AW-1:0] reg_addr,
    input wire logic [REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_DW-1:0] reg_rdata,
    input wire logic [NUM_INV-1:0] ext_fault_trig,
    input wire logic [ANGLE_W-1:0] resolver_angle,
    input wire logic [ANGLE_W-1:0] encoder_angle,
    input wire logic [17:0] cur_a,
    input wire logic [17:0] cur_b,
    input wire logic [17:0] cur_c,
    input wire logic [17:0] link_cur,
    input wire logic [17:0] vin_a,
    input wire logic [17:0] vin_b,
    input wire logic [17:0] vin_c,
    input wire logic [17:0] emf_a,
    input wire logic [17:0] emf_b,
    input wire logic [17:0] emf_c,
    input wire logic [2:0] hall,
    input wire logic [SUB_W-1:0] digital_in,
    input wire logic [SUB_W-1:0] rail_24v,
    input wire logic [SUB_W-1:0] rail_12v,
    input wire logic [SUB_W-1:0] rail_gnd,
    input wire logic [SUB_W-1:0] rail_12v_alt,
    output logic [NUM_GAINS-1:0][GAIN_W-1:0] ao_gain,
    output logic [GAIN_W-1:0] speed_factor,
    output logic [ANGLE_W-1:0] elec_angle,
    output logic [ANGLE_W-1:0] mech_angle,
    output logic [NUM_PHASE-1:0][PM_DATA_W-1:0] stator_res,
    output logic [PM_DATA_W-1:0] flux_factor_0,
    output logic [PM_DATA_W-1:0] flux_factor_1,
    output logic [PM_DATA_W-1:0] high_imp,
    output logic link_short,
    output logic ac_short,
    output logic [NUM_INV-1:0][POS_W-1:0] switch_open,
    output logic [NUM_INV-1:0][POS_W-1:0] diode_open,
    output logic [NUM_INV-1:0][POS_W-1:0] force_conduct,
    output logic [NUM_PHASE-1:0] phase_open,
    output logic [NUM_CHAN-1:0][CHAN_W-1:0] chan_word
);

    // --
    // Parameter storage
    // --
    logic [NUM_GAINS-1:0][GAIN_W-1:0] gain_q, gain_d;
    logic [GAIN_W-1:0] speed_q, speed_d;
    logic [ANGLE_W-1:0] elec_ofs_q, elec_ofs_d;
    logic [ANGLE_W-1:0] mech_ofs_q, mech_ofs_d;
    logic [GEN_DATA_W-1:0] inv1_open_q, inv1_open_d;
    logic [INV1_CTRL_W-1:0] inv1_ctrl_q, inv1_ctrl_d;
    logic [GEN_DATA_W-1:0] inv2_open_q, inv2_open_d;
    logic [POS_W-1:0] inv2_cond_q, inv2_cond_d;
    logic [NUM_PHASE-1:0][PM_DATA_W-1:0] rs_q, rs_d;
    logic [PM_DATA_W-1:0] flux0_q, flux0_d;
    logic [PM_DATA_W-1:0] flux1_q, flux1_d;
    logic [PM_DATA_W-1:0] himp_q, himp_d;

    // General words use a 12-bit index, machine words a 6-bit one
    always_comb begin
        gain_d = gain_q;
        speed_d = speed_q;
        elec_ofs_d = elec_ofs_q;
        mech_ofs_d = mech_ofs_q;
        inv1_open_d = inv1_open_q;
        inv1_ctrl_d = inv1_ctrl_q;
        inv2_open_d = inv2_open_q;
        inv2_cond_d = inv2_cond_q;
        rs_d = rs_q;
        flux0_d = flux0_q;
        flux1_d = flux1_q;
        himp_d = himp_q;
        if (gen_valid) begin
            unique case (gen_index)
                IDX_GAIN_MOTOR: gain_d[0] = gen_data[GAIN_W-1:0];
                IDX_GAIN_LINK: gain_d[1] = gen_data[GAIN_W-1:0];
                IDX_GAIN_RESOLVER: gain_d[2] = gen_data[GAIN_W-1:0];
                IDX_GAIN_BATTERY: gain_d[3] = gen_data[GAIN_W-1:0];
                IDX_SPEED_FACTOR: speed_d = gen_data[GAIN_W-1:0];
                IDX_ELEC_OFFSET: elec_ofs_d = gen_data[ANGLE_W-1:0];
                IDX_MECH_OFFSET: mech_ofs_d = gen_data[ANGLE_W-1:0];
                IDX_INV1_OPEN: inv1_open_d = gen_data;
                IDX_INV1_CTRL: inv1_ctrl_d = gen_data[INV1_CTRL_W-1:0];
                IDX_INV2_OPEN: inv2_open_d = gen_data;
                IDX_INV2_CONDUCT: inv2_cond_d = gen_data[POS_W-1:0];
                default: begin
                end
            endcase
        end
        if (pm_valid) begin
            unique case (pm_index)
                IDX_RS_A: rs_d[0] = pm_data;
                IDX_RS_B: rs_d[1] = pm_data;
                IDX_RS_C: rs_d[2] = pm_data;
                IDX_FLUX_0: flux0_d = pm_data;
                IDX_FLUX_1: flux1_d = pm_data;
                IDX_HIGH_IMP: himp_d = pm_data;
                default: begin
                end
            endcase
        end
    end

    // Gains start at unity so the analog outputs are usable before setup
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_q <= {NUM_GAINS{GAIN_RST}};
            speed_q <= '0;
            elec_ofs_q <= '0;
            mech_ofs_q <= '0;
            inv1_open_q <= '0;
            inv1_ctrl_q <= '0;
            inv2_open_q <= '0;
            inv2_cond_q <= '0;
            rs_q <= '0;
            flux0_q <= '0;
            flux1_q <= '0;
            himp_q <= HIGH_IMP_RST;
        end else begin
            gain_q <= gain_d;
            speed_q <= speed_d;
            elec_ofs_q <= elec_ofs_d;
            mech_ofs_q <= mech_ofs_d;
            inv1_open_q <= inv1_open_d;
            inv1_ctrl_q <= inv1_ctrl_d;
            inv2_open_q <= inv2_open_d;
            inv2_cond_q <= inv2_cond_d;
            rs_q <= rs_d;
            flux0_q <= flux0_d;
            flux1_q <= flux1_d;
            himp_q <= himp_d;
        end
    end

    assign ao_gain = gain_q;
    assign speed_factor = speed_q;
    assign stator_res = rs_q;
    assign flux_factor_0 = flux0_q;
    assign flux_factor_1 = flux1_q;
    assign high_imp = himp_q;

    // --
    // Sensor angle offsets
    // --
    logic [ANGLE_W-1:0] elec_q, elec_d;
    logic [ANGLE_W-1:0] mech_q, mech_d;

    // Pure fraction of a turn, so the sum wraps naturally
    always_comb begin
        elec_d = ANGLE_W'(resolver_angle + elec_ofs_q);
        mech_d = ANGLE_W'(encoder_angle + mech_ofs_q);
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            elec_q <= '0;
            mech_q <= '0;
        end else begin
            elec_q <= elec_d;
            mech_q <= mech_d;
        end
    end

    assign elec_angle = elec_q;
    assign mech_angle = mech_q;

    // --
    // Register port
    // --
    logic [RB_SPACE_BIT:0] rb_sel_q, rb_sel_d;
    logic [REG_DW-1:0] rdata_q, rdata_d;
    logic [NUM_INV-1:0] trig_clr;
    logic [NUM_INV-1:0] trig_seen_q;
    logic [NUM_INV-1:0] fault_live;
    logic [PM_DATA_W-1:0] rb_value;

    always_comb begin
        rb_value = '0;
        if (rb_sel_q[RB_SPACE_BIT]) begin
            unique case (rb_sel_q[PM_IDX_W-1:0])
                IDX_RS_A: rb_value = rs_q[0];
                IDX_RS_B: rb_value = rs_q[1];
                IDX_RS_C: rb_value = rs_q[2];
                IDX_FLUX_0: rb_value = flux0_q;
                IDX_FLUX_1: rb_value = flux1_q;
                IDX_HIGH_IMP: rb_value = himp_q;
                default: rb_value = '0;
            endcase
        end else begin
            unique case (rb_sel_q[GEN_IDX_W-1:0])
                IDX_GAIN_MOTOR: rb_value = {8'h00, gain_q[0]};
                IDX_GAIN_LINK: rb_value = {8'h00, gain_q[1]};
                IDX_GAIN_RESOLVER: rb_value = {8'h00, gain_q[2]};
                IDX_GAIN_BATTERY: rb_value = {8'h00, gain_q[3]};
                IDX_SPEED_FACTOR: rb_value = {8'h00, speed_q};
                IDX_ELEC_OFFSET: rb_value = {8'h00, elec_ofs_q};
                IDX_MECH_OFFSET: rb_value = {8'h00, mech_ofs_q};
                IDX_INV1_OPEN: rb_value = {6'h00, inv1_open_q};
                IDX_INV1_CTRL: rb_value = {13'h0000, inv1_ctrl_q};
                IDX_INV2_OPEN: rb_value = {6'h00, inv2_open_q};
                IDX_INV2_CONDUCT: rb_value = {20'h00000, inv2_cond_q};
                default: rb_value = '0;
            endcase
        end
    end

    // Read data stand for exactly one cycle, then fall back to zero
    always_comb begin
        rb_sel_d = rb_sel_q;
        trig_clr = '0;
        rdata_d = '0;
        if (reg_wr && reg_addr == REG_RB_SEL) begin
            rb_sel_d = reg_wdata[RB_SPACE_BIT:0];
        end
        if (reg_wr && reg_addr == REG_CTRL) begin
            trig_clr = reg_wdata[NUM_INV-1:0];
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_d = '0;
                REG_RB_SEL: rdata_d = {19'h00000, rb_sel_q};
                REG_RB_DATA: rdata_d = {6'h00, rb_value};
                REG_STATUS: rdata_d = {28'h0000000, trig_seen_q,
                    fault_live};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rb_sel_q <= '0;
            rdata_q <= '0;
        end else begin
            rb_sel_q <= rb_sel_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // --
    // Fault gating and decode
    // --
    logic [NUM_INV-1:0][GEN_DATA_W-1:0] open_word;
    logic [NUM_INV-1:0][POS_W-1:0] cond_word;
    logic [NUM_INV-1:0] trig_sel;
    logic [NUM_INV-1:0] trig_seen_d;
    logic faults_on;
    logic link_short_q, link_short_d;
    logic ac_short_q, ac_short_d;
    logic [NUM_PHASE-1:0] phase_open_q, phase_open_d;
    logic [NUM_INV-1:0][POS_W-1:0] sw_open_q, sw_open_d;
    logic [NUM_INV-1:0][POS_W-1:0] di_open_q, di_open_d;
    logic [NUM_INV-1:0][POS_W-1:0] cond_q, cond_d;

    assign open_word[0] = inv1_open_q;
    assign open_word[1] = inv2_open_q;
    assign cond_word[0] = inv1_ctrl_q[FX_CONDUCT_LSB +: POS_W];
    assign cond_word[1] = inv2_cond_q;
    assign trig_sel = inv1_ctrl_q[FX_TRIG_LSB +: NUM_INV];
    // Disable overrides enable when software sets both
    assign faults_on = inv1_ctrl_q[FX_ENABLE_ALL]
        && !inv1_ctrl_q[FX_DISABLE_ALL];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INV; gi++) begin : g_inv
            // Trigger latch: a trigger input sampled high wins over a clear in the same cycle
            always_comb begin
                trig_seen_d[gi] = trig_seen_q[gi];
                if (trig_clr[gi] || !trig_sel[gi]) begin
                    trig_seen_d[gi] = 1'b0;
                end
                if (trig_sel[gi] && ext_fault_trig[gi]) begin
                    trig_seen_d[gi] = 1'b1;
                end
            end
            assign fault_live[gi] = faults_on
                && (!trig_sel[gi] || trig_seen_q[gi]);
            // Bit pairs run upper then lower, phases A, B, C
            always_comb begin
                sw_open_d[gi] = '0;
                di_open_d[gi] = '0;
                cond_d[gi] = '0;
                if (fault_live[gi]) begin
                    sw_open_d[gi] = open_word[gi][FW_SW_OFF_LSB +: POS_W]
                        | open_word[gi][FW_BOTH_OFF_LSB +: POS_W];
                    di_open_d[gi] = open_word[gi][FW_DIODE_OFF_LSB +: POS_W]
                        | open_word[gi][FW_BOTH_OFF_LSB +: POS_W];
                    cond_d[gi] = cond_word[gi];
                end
            end
        end
    endgenerate

    // Inverter two has no short bits; those bits are ignored
    always_comb begin
        link_short_d = fault_live[0] && inv1_open_q[FW_LINK_SHORT];
        ac_short_d = fault_live[0] && inv1_open_q[FW_AC_SHORT];
        phase_open_d = fault_live[0]
            ? inv1_ctrl_q[FX_OPEN_PHASE_LSB +: NUM_PHASE] : '0;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_seen_q <= '0;
            link_short_q <= 1'b0;
            ac_short_q <= 1'b0;
            phase_open_q <= '0;
            sw_open_q <= '0;
            di_open_q <= '0;
            cond_q <= '0;
        end else begin
            trig_seen_q <= trig_seen_d;
            link_short_q <= link_short_d;
            ac_short_q <= ac_short_d;
            phase_open_q <= phase_open_d;
            sw_open_q <= sw_open_d;
            di_open_q <= di_open_d;
            cond_q <= cond_d;
        end
    end

    assign link_short = link_short_q;
    assign ac_short = ac_short_q;
    assign phase_open = phase_open_q;
    assign switch_open = sw_open_q;
    assign diode_open = di_open_q;
    assign force_conduct = cond_q;

    // --
    // Output channel packing
    // --
    logic [NUM_CHAN-1:0][SUB_W-1:0] sub_lo;
    logic [NUM_CHAN-1:0][SUB_W-1:0] sub_hi;

    // Dropping two low bits keeps the range and gives 16-bit halves
    always_comb begin
        sub_lo = '0;
        sub_hi = '0;
        sub_lo[0] = cur_a[17:SCALE_DROP];
        sub_hi[0] = cur_b[17:SCALE_DROP];
        sub_lo[1] = cur_c[17:SCALE_DROP];
        sub_hi[1] = elec_q[17:SCALE_DROP];
        sub_lo[2] = link_cur[17:SCALE_DROP];
        sub_lo[3] = vin_a[17:SCALE_DROP];
        sub_hi[3] = vin_b[17:SCALE_DROP];
        sub_lo[4] = vin_c[17:SCALE_DROP];
        sub_hi[5] = mech_q[17:SCALE_DROP];
        sub_lo[6] = {13'h0000, hall};
        sub_lo[7] = emf_a[17:SCALE_DROP];
        sub_hi[7] = emf_b[17:SCALE_DROP];
        sub_lo[8] = emf_c[17:SCALE_DROP];
        sub_lo[9] = digital_in;
        sub_lo[10] = rail_24v;
        sub_hi[10] = rail_12v;
        sub_lo[11] = rail_gnd;
        sub_hi[11] = rail_12v_alt;
    end

    genvar ci;
    generate
        for (ci = 0; ci < NUM_CHAN; ci++) begin : g_chan
            output_channel_pack u_pack (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .lo_in(sub_lo[ci]),
                .hi_in(sub_hi[ci]),
                .word_out(chan_word[ci])
            );
        end
    endgenerate

endmodule // tdm_param_fault_decoder

// >>> sim/tdm_param_fault_decoder_asserts.sv
// Port-level checker for the parameter decoder and channel packer
`timescale 1ns/1ps

module tdm_param_fault_decoder_asserts
    import tdm_param_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic gen_valid,
    input wire logic [GEN_IDX_W-1:0] gen_index,
    input wire logic [GEN_DATA_W-1:0] gen_data,
    input wire logic pm_valid,
    input wire logic [PM_IDX_W-1:0] pm_index,
    input wire logic [PM_DATA_W-1:0] pm_data,
    input wire logic reg_rd,
    input wire logic [REG_DW-1:0] reg_rdata,
    input wire logic [17:0] cur_a,
    input wire logic [17:0] cur_b,
    input wire logic [NUM_GAINS-1:0][GAIN_W-1:0] ao_gain,
    input wire logic [GAIN_W-1:0] speed_factor,
    input wire logic [NUM_PHASE-1:0][PM_DATA_W-1:0] stator_res,
    input wire logic [PM_DATA_W-1:0] high_imp,
    input wire logic [NUM_CHAN-1:0][CHAN_W-1:0] chan_word
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    gain_latch_a: assert property (gen_valid && gen_index == IDX_GAIN_BATTERY
        |=> ao_gain[3] == $past(gen_data[17:0])) else $error("gain");
    speed_latch_a: assert property (gen_valid && gen_index == IDX_SPEED_FACTOR
        |=> speed_factor == $past(gen_data[17:0])) else $error("speed");
    res_latch_a: assert property (pm_valid && pm_index == IDX_RS_B
        |=> stator_res[1] == $past(pm_data)) else $error("res");
    imp_latch_a: assert property (pm_valid && pm_index == IDX_HIGH_IMP
        |=> high_imp == $past(pm_data)) else $error("imp");
    gain_hold_a: assert property (!(gen_valid && gen_index == IDX_GAIN_MOTOR)
        |=> $stable(ao_gain[0])) else $error("gain hold");
    imp_hold_a: assert property (!(pm_valid && pm_index == IDX_HIGH_IMP)
        |=> $stable(high_imp)) else $error("imp hold");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("rdata idle");
    chan_pack_a: assert property (1'b1 |=> chan_word[0] ==
        {$past(cur_b[17:2]), $past(cur_a[17:2])}) else $error("ch1");
    cover property (gen_valid && gen_index == IDX_INV1_CTRL);
    cover property (pm_valid && pm_index == IDX_HIGH_IMP);
    cover property (reg_rd ##1 reg_rdata != '0);
endmodule // tdm_param_fault_decoder_asserts

bind tdm_param_fault_decoder tdm_param_fault_decoder_asserts u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .gen_valid(gen_valid),
    .gen_index(gen_index), .gen_data(gen_data), .pm_valid(pm_valid),
    .pm_index(pm_index), .pm_data(pm_data), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cur_a(cur_a), .cur_b(cur_b), .ao_gain(ao_gain),
    .speed_factor(speed_factor), .stator_res(stator_res),
    .high_imp(high_imp), .chan_word(chan_word));

// >>> sim/param_host_model.sv
// Host model that sends indexed parameter words one at a time
`timescale 1ns/1ps

module param_host_model
    import tdm_param_pkg::*;
(
    input wire logic sys_clk,
    output logic gen_valid,
    output logic [GEN_IDX_W-1:0] gen_index,
    output logic [GEN_DATA_W-1:0] gen_data,
    output logic pm_valid,
    output logic [PM_IDX_W-1:0] pm_index,
    output logic [PM_DATA_W-1:0] pm_data
);
    initial begin
        {gen_valid, gen_index, gen_data} = '0;
        {pm_valid, pm_index, pm_data} = '0;
    end
    // Released lines show the inverse, so stale words are never trusted
    task automatic send_gen(input logic [11:0] i, input logic [19:0] d);
        @(posedge sys_clk);
        gen_valid <= 1'b1;
        gen_index <= i;
        gen_data <= d;
        @(posedge sys_clk);
        gen_valid <= 1'b0;
        gen_index <= ~i;
        gen_data <= ~d;
    endtask
    task automatic send_pm(input logic [5:0] i, input logic [25:0] d);
        @(posedge sys_clk);
        pm_valid <= 1'b1;
        pm_index <= i;
        pm_data <= d;
        @(posedge sys_clk);
        pm_valid <= 1'b0;
        pm_index <= ~i;
        pm_data <= ~d;
    endtask
endmodule // param_host_model

// >>> sim/tb_top.sv
// Self-checking bench for the parameter decoder and channel packer
`timescale 1ns/1ps

module tb_top
    import tdm_param_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic gen_valid, pm_valid, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [GEN_IDX_W-1:0] gen_index;
    logic [GEN_DATA_W-1:0] gen_data;
    logic [PM_IDX_W-1:0] pm_index;
    logic [PM_DATA_W-1:0] pm_data, flux0, flux1, high_imp;
    logic [REG_AW-1:0] reg_addr = '0;
    logic [REG_DW-1:0] reg_wdata = '0, reg_rdata;
    logic [NUM_INV-1:0] ext_fault_trig = '0;
    logic [ANGLE_W-1:0] res_ang = '0, enc_ang = '0, elec_angle, mech_angle;
    logic [17:0] an [0:9] = '{default: '0};
    logic [15:0] rl [0:4] = '{default: '0};
    logic [2:0] hall = '0;
    logic [NUM_GAINS-1:0][GAIN_W-1:0] ao_gain;
    logic [GAIN_W-1:0] speed_factor;
    logic [NUM_PHASE-1:0][PM_DATA_W-1:0] stator_res;
    logic link_short, ac_short;
    logic [NUM_INV-1:0][POS_W-1:0] sw_open, dio_open, conduct;
    logic [NUM_PHASE-1:0] phase_open;
    logic [NUM_CHAN-1:0][CHAN_W-1:0] chan_word;
    int n_fail = 0, compares = 0;

    param_host_model u_param_host_model (.sys_clk(sys_clk),
        .gen_valid(gen_valid), .gen_index(gen_index), .gen_data(gen_data),
        .pm_valid(pm_valid), .pm_index(pm_index), .pm_data(pm_data));
    tdm_param_fault_decoder u_tdm_param_fault_decoder (.sys_clk(sys_clk),
        .reset_n(reset_n), .gen_valid(gen_valid), .gen_index(gen_index),
        .gen_data(gen_data), .pm_valid(pm_valid), .pm_index(pm_index),
        .pm_data(pm_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_fault_trig(ext_fault_trig), .resolver_angle(res_ang),
        .encoder_angle(enc_ang), .cur_a(an[0]), .cur_b(an[1]),
        .cur_c(an[2]), .link_cur(an[3]), .vin_a(an[4]), .vin_b(an[5]),
        .vin_c(an[6]), .emf_a(an[7]), .emf_b(an[8]), .emf_c(an[9]),
        .hall(hall), .digital_in(rl[0]), .rail_24v(rl[1]), .rail_12v(rl[2]),
        .rail_gnd(rl[3]), .rail_12v_alt(rl[4]), .ao_gain(ao_gain),
        .speed_factor(speed_factor), .elec_angle(elec_angle),
        .mech_angle(mech_angle), .stator_res(stator_res),
        .flux_factor_0(flux0), .flux_factor_1(flux1), .high_imp(high_imp),
        .link_short(link_short), .ac_short(ac_short), .switch_open(sw_open),
        .diode_open(dio_open), .force_conduct(conduct),
        .phase_open(phase_open), .chan_word(chan_word));

    initial forever #12.5 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic gs(input logic [11:0] i, input logic [19:0] d);
        u_param_host_model.send_gen(i, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask
    task automatic t_gen;
        logic [11:0] idx [5] = '{IDX_GAIN_MOTOR, IDX_GAIN_LINK,
            IDX_GAIN_RESOLVER, IDX_GAIN_BATTERY, IDX_SPEED_FACTOR};
        tick(0);
        chk("gain_rst", ao_gain[2], GAIN_RST);
        for (int k = 0; k < 5; k++) begin
            gs(idx[k], 20'hf8001 + k);
            tick(0);
            chk("gen", k < 4 ? ao_gain[k] : speed_factor, 32'h38001 + k);
        end
        gs(12'h077, 20'h0);
        tick(0);
        chk("rsvd", speed_factor, 32'h38005);
        wr(REG_RB_SEL, 32'h07d);
        rd(REG_RB_DATA, 32'h38005);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_pm;
        logic [5:0] idx [7] = '{IDX_RS_A, IDX_RS_B, IDX_RS_C, IDX_FLUX_0,
            IDX_FLUX_1, IDX_HIGH_IMP, 6'h04};
        chk("imp_rst", high_imp, HIGH_IMP_RST);
        for (int k = 0; k < 7; k++) u_param_host_model.send_pm(idx[k],
            26'h2000010 + k);
        tick(0);
        chk("res_c", stator_res[2], 32'h2000012);
        chk("flux", {flux1[15:0], flux0[15:0]}, 32'h00140013);
        chk("imp", high_imp, 32'h2000015);
        wr(REG_RB_SEL, 32'h1009);
        rd(REG_RB_DATA, 32'h2000015);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        tick(1);
        chk("imp_rst2", high_imp, HIGH_IMP_RST);
        @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask
    task automatic t_fault;
        gs(IDX_INV1_OPEN, 20'h04213);
        tick(1);
        chk("off", sw_open[0], 32'h0);
        gs(IDX_INV1_CTRL, 20'h00560);
        tick(1);
        chk("open", {sw_open[0], dio_open[0]}, 32'h143);
        chk("short", {link_short, ac_short}, 32'h3);
        chk("cond", {conduct[0], phase_open}, 32'h105);
        gs(IDX_INV1_CTRL, 20'h00760);
        tick(1);
        chk("dis", {conduct[0], sw_open[0]}, 32'h0);
    endtask
    task automatic t_trig;
        gs(IDX_INV1_CTRL, 20'h00c20);
        tick(1);
        chk("wait", conduct[0], 32'h0);
        rd(REG_STATUS, 32'h2);
        @(posedge sys_clk);
        ext_fault_trig <= 2'b01;
        tick(3);
        chk("trig", conduct[0], 32'h20);
        @(posedge sys_clk);
        ext_fault_trig <= 2'b00;
        rd(REG_STATUS, 32'h7);
        wr(REG_CTRL, 32'h1);
        tick(2);
        chk("clr", conduct[0], 32'h0);
    endtask
    task automatic t_inv2;
        gs(IDX_INV2_OPEN, 20'h04213);
        gs(IDX_INV2_CONDUCT, 20'h0000a);
        tick(1);
        chk("inv2", {sw_open[1], dio_open[1], conduct[1]}, 32'h50ca);
        chk("short2", {link_short, ac_short}, 32'h0);
    endtask
    task automatic t_angle;
        @(posedge sys_clk);
        {res_ang, enc_ang} <= {18'h3ffff, 18'h10000};
        gs(IDX_ELEC_OFFSET, 20'h00006);
        gs(IDX_MECH_OFFSET, 20'h00010);
        tick(2);
        chk("elec", elec_angle, 32'h5);
        chk("mech", mech_angle, 32'h10010);
        chk("ang_ch", {chan_word[1][31:16], chan_word[5][31:16]}, 32'h14004);
    endtask
    task automatic t_chan;
        @(posedge sys_clk);
        {an[0], an[1], an[3], hall} <= {18'h2fffc, 18'h7, 18'h3fff4, 3'h5};
        {rl[0], rl[1], rl[2], rl[3], rl[4]} <= 80'h00ff1234abcd80017ffe;
        for (int k = 4; k < 10; k++) an[k] <= 18'h1000 * k;
        tick(2);
        chk("ch1", chan_word[0], 32'h0001bfff);
        chk("ch3", chan_word[2], 32'h0000fffd);
        chk("ch7", chan_word[6], 32'h5);
        chk("ch11", chan_word[10], 32'habcd1234);
        chk("ch12", chan_word[11], 32'h7ffe8001);
    endtask
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_gen;
        t_pm;
        t_fault;
        t_trig;
        t_inv2;
        t_angle;
        t_chan;
        stop_test;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_fail++;
        stop_test;
    end
endmodule // tb_top
